// ---- logic/mct_defs.svh ----
`ifndef MCT_DEFS_SVH
`define MCT_DEFS_SVH

`define MCT_OFF_CTRL 12'h000
`define MCT_OFF_COUNT 12'h004
`define MCT_OFF_PRESCALE 12'h008
`define MCT_OFF_PRESCALE_CNT 12'h00C
`define MCT_OFF_MODE 12'h010
`define MCT_OFF_INT_EN 12'h014
`define MCT_OFF_STATUS 12'h018
`define MCT_OFF_EXT_MATCH 12'h01C
`define MCT_OFF_CAP_CTRL 12'h020
`define MCT_OFF_MATCH0 12'h040
`define MCT_OFF_MATCH_CFG0 12'h050
`define MCT_OFF_CAPTURE0 12'h060

`define MCT_CTRL_ENABLE_BIT 0
`define MCT_CTRL_RESET_BIT 1
`define MCT_CTRL_INT_SET_BIT 2
`define MCT_CTRL_INT_CLR_BIT 3

`define MCT_NUM_MATCH 4
`define MCT_NUM_CAPTURE 3
`define MCT_PERIOD_CHANNEL 3
`define MCT_NUM_FLAGS 7

`endif

// ---- logic/mct_pkg.sv ----
package mct_pkg;
  typedef enum logic [1:0] {
    MCT_OUT_NONE,
    MCT_OUT_CLEAR,
    MCT_OUT_SET,
    MCT_OUT_TOGGLE
  } mct_out_action_type;

  typedef enum logic [1:0] {
    MCT_MODE_TIMER,
    MCT_MODE_COUNT_RISE,
    MCT_MODE_COUNT_FALL,
    MCT_MODE_COUNT_BOTH
  } mct_count_mode_type;

  typedef struct packed {
    logic reset_on_match;
    logic stop_on_match;
    logic pwm_enable;
    mct_out_action_type action;
  } mct_match_cfg_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mct_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mct_apb_rsp_type;
endpackage

// ---- logic/mct_edge_detect.sv ----
`timescale 1ns/1ps
module mct_edge_detect (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sig_in,
  input wire logic rise_en,
  input wire logic fall_en,
  output logic edge_pulse
);
  logic prev_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sig_in;
    end
  end

  assign edge_pulse = (rise_en & sig_in & ~prev_reg) | (fall_en & ~sig_in & prev_reg);
endmodule

// ---- logic/mct_timer.sv ----
`timescale 1ns/1ps
`include "mct_defs.svh"
// Notes on behaviour
// - Four match channels each compare a written value against the count.
// - Reset-on-match returns the count to zero on that channel's match.
// - Stop-on-match clears the counter enable on that channel's match.
// - Each match, except on a PWM width channel, applies none, clear, set or toggle to its match output.
// - Software may preset each non-PWM match output level directly.
// - Match with its interrupt enable set raises the interrupt request.
// - Three capture channels latch the count on rise, fall or both edges.
// - Capture with its interrupt enable set raises the interrupt request.
// - Counter modes count edges of a selected capture input, not the prescaler.
// - Seven status flags, four match and three capture, read together.
// - Writing ones to the status register clears only those flags.
// - Seven interrupt enables readable, settable and clearable as a mask.
// - In PWM mode channel 3 sets the period and drives no PWM output.
// - PWM channel with interrupt enabled interrupts at its pulse-width match.
// - Software counter reset clears count and prescale count at next edge.
// - Each PWM channel holds its own width, sharing channel 3 period.
module mct_timer #(
  parameter int COUNT_WIDTH = 32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire mct_pkg::mct_apb_req_type apb_req,
  output mct_pkg::mct_apb_rsp_type apb_rsp,
  input wire logic [2:0] capture_in,
  output logic [3:0] external_match_output,
  output logic irq
);
  import mct_pkg::*;

  localparam int NM = `MCT_NUM_MATCH;
  localparam int NC = `MCT_NUM_CAPTURE;
  localparam int NF = `MCT_NUM_FLAGS;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic enable_reg;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [31:0] prescale_reg;
  logic [31:0] prescale_cnt_reg;
  mct_count_mode_type mode_reg;
  logic [1:0] input_sel_reg;
  logic [NF-1:0] int_en_reg;
  logic [NF-1:0] status_reg;
  logic [NM-1:0] ext_match_reg;
  logic [COUNT_WIDTH-1:0] match_reg [NM];
  mct_match_cfg_type match_cfg_reg [NM];
  logic [1:0] cap_edge_reg [NC];
  logic [COUNT_WIDTH-1:0] capture_reg [NC];
  logic irq_reg;
  mct_apb_rsp_type rsp_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_stb;
  logic rd_stb;
  logic [11:0] addr;
  logic [31:0] wdata;

  assign wr_stb = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_stb = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
  assign addr = apb_req.paddr;
  assign wdata = apb_req.pwdata;

  logic wr_ctrl;
  logic soft_reset;
  assign wr_ctrl = wr_stb && addr == `MCT_OFF_CTRL;
  assign soft_reset = wr_ctrl && wdata[`MCT_CTRL_RESET_BIT];

  // ----------------------------------------------------------------
  // Capture input edges
  // ----------------------------------------------------------------
  logic [NC-1:0] cap_event;
  logic [NC-1:0] count_edge;

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_cap
      mct_edge_detect u_cap_edge (
        .core_clk(core_clk),
        .reset(reset),
        .sig_in(capture_in[gi]),
        .rise_en(cap_edge_reg[gi][0]),
        .fall_en(cap_edge_reg[gi][1]),
        .edge_pulse(cap_event[gi])
      );
      mct_edge_detect u_cnt_edge (
        .core_clk(core_clk),
        .reset(reset),
        .sig_in(capture_in[gi]),
        .rise_en(mode_reg == MCT_MODE_COUNT_RISE || mode_reg == MCT_MODE_COUNT_BOTH),
        .fall_en(mode_reg == MCT_MODE_COUNT_FALL || mode_reg == MCT_MODE_COUNT_BOTH),
        .edge_pulse(count_edge[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Tick and match detection
  // ----------------------------------------------------------------
  logic prescale_done;
  logic tick;
  logic [NM-1:0] match_hit;
  logic any_reset_hit;
  logic any_stop_hit;

  assign prescale_done = prescale_cnt_reg >= prescale_reg;
  always_comb begin
    if (mode_reg == MCT_MODE_TIMER) begin
      tick = enable_reg & prescale_done;
    end else if (input_sel_reg < 2'(NC)) begin
      tick = enable_reg & count_edge[input_sel_reg];
    end else begin
      tick = 1'b0;
    end
  end

  // A match is seen on the tick in which the count equals the compare value.
  always_comb begin
    any_reset_hit = 1'b0;
    any_stop_hit = 1'b0;
    for (int i = 0; i < NM; i++) begin
      match_hit[i] = tick && count_reg == match_reg[i];
      if (match_hit[i] && (match_cfg_reg[i].reset_on_match ||
          (i == `MCT_PERIOD_CHANNEL && match_cfg_reg[i].pwm_enable))) begin
        any_reset_hit = 1'b1;
      end
      if (match_hit[i] && match_cfg_reg[i].stop_on_match) begin
        any_stop_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and count
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prescale_cnt_reg <= 32'h00000000;
    end else if (soft_reset) begin
      prescale_cnt_reg <= 32'h00000000;
    end else if (wr_stb && addr == `MCT_OFF_PRESCALE_CNT) begin
      prescale_cnt_reg <= wdata;
    end else if (enable_reg && mode_reg == MCT_MODE_TIMER) begin
      prescale_cnt_reg <= prescale_done ? 32'h00000000 : prescale_cnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_reg <= '0;
    end else if (soft_reset) begin
      count_reg <= '0;
    end else if (wr_stb && addr == `MCT_OFF_COUNT) begin
      count_reg <= wdata[COUNT_WIDTH-1:0];
    end else if (any_reset_hit) begin
      count_reg <= '0;
    end else if (tick && !any_stop_hit) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      enable_reg <= 1'b0;
    end else if (any_stop_hit) begin
      enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      enable_reg <= wdata[`MCT_CTRL_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Match outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ext_match_reg <= '0;
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (match_cfg_reg[i].pwm_enable && i != `MCT_PERIOD_CHANNEL) begin
          // PWM output is low up to the width and high above it to the period end.
          if (any_reset_hit) begin
            ext_match_reg[i] <= 1'b0;
          end else if (match_hit[i]) begin
            ext_match_reg[i] <= 1'b1;
          end
        end else if (match_hit[i]) begin
          case (match_cfg_reg[i].action)
            MCT_OUT_CLEAR: ext_match_reg[i] <= 1'b0;
            MCT_OUT_SET: ext_match_reg[i] <= 1'b1;
            MCT_OUT_TOGGLE: ext_match_reg[i] <= ~ext_match_reg[i];
            default: ext_match_reg[i] <= ext_match_reg[i];
          endcase
        end else if (wr_stb && addr == `MCT_OFF_EXT_MATCH) begin
          ext_match_reg[i] <= wdata[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Captures
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NC; i++) begin
        capture_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (cap_event[i]) begin
          capture_reg[i] <= count_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags and interrupt
  // ----------------------------------------------------------------
  logic [NF-1:0] events;
  assign events = {cap_event, match_hit};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_reg <= '0;
    end else begin
      for (int i = 0; i < NF; i++) begin
        if (events[i]) begin
          status_reg[i] <= 1'b1;
        end else if (wr_stb && addr == `MCT_OFF_STATUS && wdata[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      int_en_reg <= '0;
    end else if (wr_stb && addr == `MCT_OFF_INT_EN) begin
      int_en_reg <= wdata[NF-1:0];
    end else if (wr_ctrl && wdata[`MCT_CTRL_INT_SET_BIT]) begin
      int_en_reg <= int_en_reg | wdata[8+NF-1:8];
    end else if (wr_ctrl && wdata[`MCT_CTRL_INT_CLR_BIT]) begin
      int_en_reg <= int_en_reg & ~wdata[8+NF-1:8];
    end
  end

  // PWM channels raise their request at the width match like any match.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & int_en_reg);
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prescale_reg <= 32'h00000000;
      mode_reg <= MCT_MODE_TIMER;
      input_sel_reg <= 2'h0;
    end else if (wr_stb && addr == `MCT_OFF_PRESCALE) begin
      prescale_reg <= wdata;
    end else if (wr_stb && addr == `MCT_OFF_MODE) begin
      mode_reg <= mct_count_mode_type'(wdata[1:0]);
      input_sel_reg <= wdata[3:2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NM; i++) begin
        match_reg[i] <= '0;
        match_cfg_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (wr_stb && addr == `MCT_OFF_MATCH0 + 12'(4 * i)) begin
          match_reg[i] <= wdata[COUNT_WIDTH-1:0];
        end
        if (wr_stb && addr == `MCT_OFF_MATCH_CFG0 + 12'(4 * i)) begin
          match_cfg_reg[i] <= wdata[4:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NC; i++) begin
        cap_edge_reg[i] <= 2'h0;
      end
    end else if (wr_stb && addr == `MCT_OFF_CAP_CTRL) begin
      for (int i = 0; i < NC; i++) begin
        cap_edge_reg[i] <= wdata[2*i +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rdata;
  logic hit;

  always_comb begin
    rdata = 32'h00000000;
    hit = 1'b1;
    case (addr)
      `MCT_OFF_CTRL: rdata[`MCT_CTRL_ENABLE_BIT] = enable_reg;
      `MCT_OFF_COUNT: rdata[COUNT_WIDTH-1:0] = count_reg;
      `MCT_OFF_PRESCALE: rdata = prescale_reg;
      `MCT_OFF_PRESCALE_CNT: rdata = prescale_cnt_reg;
      `MCT_OFF_MODE: rdata[3:0] = {input_sel_reg, mode_reg};
      `MCT_OFF_INT_EN: rdata[NF-1:0] = int_en_reg;
      `MCT_OFF_STATUS: rdata[NF-1:0] = status_reg;
      `MCT_OFF_EXT_MATCH: rdata[NM-1:0] = ext_match_reg;
      `MCT_OFF_CAP_CTRL: rdata[5:0] = {cap_edge_reg[2], cap_edge_reg[1], cap_edge_reg[0]};
      default: begin
        hit = 1'b0;
        for (int i = 0; i < NM; i++) begin
          if (addr == `MCT_OFF_MATCH0 + 12'(4 * i)) begin
            rdata[COUNT_WIDTH-1:0] = match_reg[i];
            hit = 1'b1;
          end
          if (addr == `MCT_OFF_MATCH_CFG0 + 12'(4 * i)) begin
            rdata[4:0] = match_cfg_reg[i];
            hit = 1'b1;
          end
        end
        for (int i = 0; i < NC; i++) begin
          if (addr == `MCT_OFF_CAPTURE0 + 12'(4 * i)) begin
            rdata[COUNT_WIDTH-1:0] = capture_reg[i];
            hit = 1'b1;
          end
        end
      end
    endcase
  end

  // Zero wait states: pready is registered from the setup cycle, so it is high in the first access cycle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.pready <= apb_req.psel & ~apb_req.penable;
      rsp_reg.pslverr <= apb_req.psel & ~apb_req.penable & ~hit;
      rsp_reg.prdata <= (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) ? rdata : 32'h0;
    end
  end

  assign apb_rsp = rsp_reg;
  assign external_match_output = ext_match_reg;
  assign irq = irq_reg;

  logic unused_rd;
  assign unused_rd = rd_stb;
endmodule

// ---- sim/mct_asserts.sv ----
`timescale 1ns/1ps
`include "mct_defs.svh"
module mct_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire mct_pkg::mct_apb_req_type apb_req,
  input wire mct_pkg::mct_apb_rsp_type apb_rsp,
  input wire logic [2:0] capture_in,
  input wire logic [3:0] external_match_output,
  input wire logic irq
);
  import mct_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic acc;
  assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
  setup_ready_a: assert property (
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (
    apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held too long");
  err_ready_a: assert property (
    apb_rsp.pslverr |-> apb_rsp.pready) else $error("pslverr without pready");
  err_data_a: assert property (
    apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0) else $error("refused read data");
  status_bits_a: assert property (
    acc && !apb_req.pwrite && apb_req.paddr == `MCT_OFF_STATUS
    |-> apb_rsp.prdata[31:7] == 25'h0) else $error("status spare bits set");
  inten_bits_a: assert property (
    acc && !apb_req.pwrite && apb_req.paddr == `MCT_OFF_INT_EN
    |-> apb_rsp.prdata[31:7] == 25'h0) else $error("enable spare bits set");
  irq_reset_a: assert property (
    $fell(reset) |-> !irq ##1 !irq) else $error("irq high after reset");
  preset_out_a: assert property (
    acc && apb_req.pwrite && apb_req.paddr == `MCT_OFF_EXT_MATCH
    |=> external_match_output == $past(apb_req.pwdata[3:0]))
    else $error("match output preset lost");
endmodule

// ---- sim/mct_pin_model.sv ----
`timescale 1ns/1ps
module mct_pin_model (
  input wire logic core_clk,
  output logic [2:0] capture_in
);
  initial begin
    capture_in = 3'h0;
  end
  // Pins change just after a clock edge, as a synchronous source would.
  task automatic drive(input logic [2:0] v);
    @(posedge core_clk);
    capture_in <= v;
  endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`include "mct_defs.svh"
module testbench;
  import mct_pkg::*;
  logic core_clk;
  logic reset;
  mct_apb_req_type req;
  mct_apb_rsp_type rsp;
  logic [2:0] capture_in;
  logic [3:0] ext_out;
  logic [3:0] ext_exp;
  logic irq;
  logic [31:0] q;
  logic [31:0] a;
  logic err_q;
  int err_total;
  int num_checks;
  int cyc;
  logic [11:0] rst_addr [7];
  mct_timer uut (.core_clk(core_clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .capture_in(capture_in), .external_match_output(ext_out), .irq(irq));
  mct_pin_model pins (.core_clk(core_clk), .capture_in(capture_in));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, ad, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    @(posedge core_clk);
    while (rsp.pready !== 1'b1) @(posedge core_clk);
    q = rsp.prdata;
    err_q = rsp.pslverr;
    req <= '0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e, input string n);
    apb(1'b0, ad, 32'h0);
    chk(n, q, e);
  endtask
  initial begin
    req = '0;
    reset = 1'b1;
    rst_addr = '{`MCT_OFF_CTRL, `MCT_OFF_COUNT, `MCT_OFF_PRESCALE, `MCT_OFF_PRESCALE_CNT,
      `MCT_OFF_MODE, `MCT_OFF_INT_EN, `MCT_OFF_STATUS};
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (rst_addr[i]) begin
      rd(rst_addr[i], 32'h0, "reset value");
    end
    chk("reset outputs", {ext_out, irq}, 5'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped err", err_q, 32'h1);
    chk("unmapped data", q, 32'h0);
    wr(`MCT_OFF_CTRL, 32'h5504);
    rd(`MCT_OFF_INT_EN, 32'h55, "mask set");
    wr(`MCT_OFF_CTRL, 32'h0508);
    rd(`MCT_OFF_INT_EN, 32'h50, "mask clear");
    wr(`MCT_OFF_PRESCALE, 32'h3);
    wr(`MCT_OFF_CTRL, 32'h1);
    // With prescale 3 the first tick lands four edges after the enable write.
    rd(`MCT_OFF_COUNT, 32'h0, "count start");
    a = q;
    repeat (37) @(posedge core_clk);
    rd(`MCT_OFF_COUNT, 32'd10, "count run");
    chk("prescaled ticks", q - a, 32'd10);
    wr(`MCT_OFF_CTRL, 32'h0);
    rd(`MCT_OFF_COUNT, 32'd11, "count stop");
    a = q;
    repeat (20) @(posedge core_clk);
    rd(`MCT_OFF_COUNT, a, "held count");
    wr(`MCT_OFF_CTRL, 32'h2);
    rd(`MCT_OFF_COUNT, 32'h0, "count reset");
    rd(`MCT_OFF_PRESCALE_CNT, 32'h0, "prescale reset");
    // Lower values on later channels keep earlier channels from matching.
    // Channel 2 already matches on the first pass, so its enabled request stays up.
    wr(`MCT_OFF_PRESCALE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(12'(`MCT_OFF_MATCH0 + 4 * i), 32'(20 - 3 * i));
    end
    wr(`MCT_OFF_INT_EN, 32'h4);
    wr(`MCT_OFF_EXT_MATCH, 32'hB);
    ext_exp = 4'hB;
    for (int i = 0; i < 4; i++) begin
      wr(12'(`MCT_OFF_MATCH_CFG0 + 4 * i), {27'h0, i == 3, 1'b1, 1'b0, 2'(i)});
      wr(`MCT_OFF_CTRL, 32'h2);
      wr(`MCT_OFF_CTRL, 32'h1);
      repeat (30) @(posedge core_clk);
      rd(`MCT_OFF_COUNT, (i == 3) ? 32'h0 : 32'(20 - 3 * i), "match stop");
      ext_exp[i] = (i == 0) ? ext_exp[i] : (i == 1) ? 1'b0 : (i == 2) ? 1'b1 : ~ext_exp[i];
      chk("match output", ext_out, ext_exp);
      chk("match irq", irq, 1'b1);
    end
    rd(`MCT_OFF_STATUS, 32'hF, "match flags");
    wr(`MCT_OFF_STATUS, 32'h5);
    rd(`MCT_OFF_STATUS, 32'hA, "flag clear");
    wr(`MCT_OFF_STATUS, 32'h7F);
    wr(`MCT_OFF_INT_EN, 32'h20);
    wr(`MCT_OFF_CAP_CTRL, 32'h39);
    wr(`MCT_OFF_COUNT, 32'h1234);
    pins.drive(3'b111);
    repeat (4) @(posedge core_clk);
    chk("capture irq off", irq, 1'b0);
    wr(`MCT_OFF_COUNT, 32'h55);
    pins.drive(3'b000);
    repeat (4) @(posedge core_clk);
    chk("capture irq on", irq, 1'b1);
    rd(`MCT_OFF_CAPTURE0, 32'h1234, "rise capture");
    rd(12'(`MCT_OFF_CAPTURE0 + 4), 32'h55, "fall capture");
    rd(12'(`MCT_OFF_CAPTURE0 + 8), 32'h55, "both capture");
    rd(`MCT_OFF_STATUS, 32'h70, "capture flags");
    wr(`MCT_OFF_MODE, 32'h5);
    wr(`MCT_OFF_COUNT, 32'h0);
    wr(`MCT_OFF_CTRL, 32'h1);
    repeat (3) begin
      pins.drive(3'b011);
      repeat (3) @(posedge core_clk);
      pins.drive(3'b000);
      repeat (3) @(posedge core_clk);
    end
    rd(`MCT_OFF_COUNT, 32'h3, "edge count");
    wr(`MCT_OFF_CTRL, 32'h0);
    wr(`MCT_OFF_MODE, 32'h0);
    // One shared period on channel 3, width on channel 0 only.
    wr(`MCT_OFF_STATUS, 32'h7F);
    wr(`MCT_OFF_INT_EN, 32'h1);
    wr(`MCT_OFF_MATCH0 + 12'hC, 32'h9);
    wr(`MCT_OFF_MATCH0, 32'h4);
    wr(`MCT_OFF_MATCH_CFG0 + 12'hC, 32'h4);
    wr(`MCT_OFF_MATCH_CFG0, 32'h4);
    wr(`MCT_OFF_COUNT, 32'h0);
    wr(`MCT_OFF_CTRL, 32'h1);
    repeat (20) @(posedge core_clk);
    a = 0;
    q = 0;
    repeat (40) begin
      @(posedge core_clk);
      a = a + ext_out[0];
      q = q + ext_out[3];
    end
    chk("pwm high cycles", a, 32'd20);
    chk("period output", q, 32'd0);
    chk("pwm irq", irq, 1'b1);
    report_and_stop();
  end
endmodule
bind mct_timer mct_asserts mct_chk (.core_clk(core_clk), .reset(reset), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .capture_in(capture_in), .external_match_output(external_match_output),
  .irq(irq));
